// *** design/itami_consts.svh ***
// Purpose: Register offsets, field positions, reset values and fixed codes of the
//          isochronous transmitter audio and MIDI insertion block.
// Assumes: Included by the package and by the design modules.
// Notes:   Addresses are full byte addresses on the register bus.
`ifndef ITAMI_CONSTS_SVH
`define ITAMI_CONSTS_SVH

`define ITAMI_ADDR_CFG          32'hcf00_00d4
`define ITAMI_ADDR_MAP          32'hcf00_00d8
`define ITAMI_ADDR_STAT         32'hcf00_00fc

`define ITAMI_CFG_MUTE_N_BIT    31
`define ITAMI_CFG_MIDI_ON_BIT   30
`define ITAMI_CFG_RESET         32'h0000_0000
`define ITAMI_MAP_RESET         32'h0000_0000

`define ITAMI_MIDI_PORTS        8
`define ITAMI_MAP_FIELD_W       4
`define ITAMI_MAP_SEL_W         3

`define ITAMI_MUTED_WORD        32'h0000_0000
`define ITAMI_MIDI_LABEL_DATA   8'h81
`define ITAMI_MIDI_LABEL_EMPTY  8'h80
`define ITAMI_MIDI_NO_BYTE      8'h00
`define ITAMI_MIDI_PAD          16'h0000

`define ITAMI_RESP_OKAY         2'b00
`define ITAMI_RESP_SLVERR       2'b10

`endif

// *** design/itami_pkg.sv ***
// Purpose: Types and shared helpers of the audio and MIDI insertion block.
// Assumes: itami_consts.svh is on the include path.
// Notes:   Bus fields keep their published signal names.
`include "itami_consts.svh"

package itami_pkg;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } itami_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } itami_axil_rsp_t;

  // One quadlet of a data block on its way to the packet builder.
  typedef struct packed {
    logic        last;
    logic [2:0]  plug;
    logic [31:0] data;
  } itami_quad_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        mute_n;
    logic        midi_insert_on;
    logic [31:0] port_map;
    logic [7:0]  midi_ack;
    logic [15:0] midi_cnt;
    logic [15:0] blk_cnt;
  } itami_top_st_t;

  typedef struct packed {
    logic        in_ready;
    logic        out_valid;
    itami_quad_t quad;
  } itami_stage_st_t;

  function automatic logic port_on(input logic [31:0] port_map, input int unsigned idx);
    return port_map[idx * `ITAMI_MAP_FIELD_W + `ITAMI_MAP_SEL_W];
  endfunction

  function automatic logic [2:0] port_plug_sel(input logic [31:0] port_map, input int unsigned idx);
    return port_map[idx * `ITAMI_MAP_FIELD_W +: `ITAMI_MAP_SEL_W];
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old_word, input logic [31:0] new_word,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// *** design/itami_midi_pick.sv ***
// Purpose: Chooses the MIDI port whose byte fills the MIDI quadlet of a data block.
// Assumes: Purely combinational; the caller registers the outcome.
// Notes:   When several enabled ports map to one plug, the lowest port number wins.
`include "itami_consts.svh"

module itami_midi_pick (
  // Port configuration.
  input  logic [31:0]      port_map,
  // Plug slot of the current data block.
  input  logic [2:0]       plug,
  // MIDI sources.
  input  logic [7:0]       src_valid,
  input  logic [7:0][7:0]  src_byte,
  // Choice.
  output logic             hit,
  output logic [2:0]       port,
  output logic [7:0]       pick_byte
);

  always_comb begin
    hit       = 1'b0;
    port      = 3'h0;
    pick_byte = `ITAMI_MIDI_NO_BYTE;
    for (int i = `ITAMI_MIDI_PORTS - 1; i >= 0; i--) begin
      if (itami_pkg::port_on(port_map, i) && itami_pkg::port_plug_sel(port_map, i) == plug
          && src_valid[i]) begin // [RULE_07]
        hit       = 1'b1;
        port      = 3'(i);
        pick_byte = src_byte[i];
      end
    end
  end

endmodule

// *** design/itami_out_stage.sv ***
// Purpose: Holds one outgoing quadlet for the packet builder.
// Assumes: Source and sink run on aclk.
// Notes:   Ready is registered, so the stage takes at most one quadlet every second cycle.
`include "itami_consts.svh"

module itami_out_stage (
  // Clock and reset.
  input  logic                   aclk,
  input  logic                   aresetn,
  // Upstream.
  input  logic                   in_valid,
  input  itami_pkg::itami_quad_t in_quad,
  output logic                   in_ready,
  // Silence control.
  input  logic                   mute_n,
  // Downstream.
  output logic                   out_valid,
  output itami_pkg::itami_quad_t out_quad,
  input  logic                   out_ready
);

  localparam itami_pkg::itami_stage_st_t ST_RST = '{in_ready: 1'b1, default: '0};

  itami_pkg::itami_stage_st_t st_q;
  itami_pkg::itami_stage_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (st_q.out_valid && out_ready) begin
      st_d.out_valid = 1'b0;
    end
    if (in_valid && st_q.in_ready) begin
      st_d.out_valid = 1'b1;
      st_d.quad      = in_quad;
    end
    // A quadlet already held is silenced too once the control drops.
    if (!mute_n) begin
      st_d.quad.data = `ITAMI_MUTED_WORD; // [RULE_01]
    end
    st_d.in_ready = !st_d.out_valid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign in_ready  = st_q.in_ready;
  assign out_valid = st_q.out_valid;
  assign out_quad  = st_q.quad;

endmodule

// *** design/itami_top.sv ***
// Purpose: Audio data configuration of an isochronous transmitter: silences the
//          sample stream and fills the MIDI quadlet of each data block.
// Assumes: One clock, aclk; registers reached over AXI4-Lite; MIDI sources and the
//          packet builder run on aclk.
// Notes:   One write and one read are served at a time on the register bus.
//
// Overview of operation
// RULE_01 - While the silence control is low every quadlet sent out is forced to the muted value; the code mutes a held quadlet one cycle late.
// RULE_02 - Software sets the silence control high to let samples through, and it is low after reset.
// RULE_03 - With MIDI insertion on, the last quadlet of each data block carries MIDI instead of audio.
// RULE_04 - With MIDI insertion off, no quadlet is reserved or filled for MIDI.
// RULE_05 - Eight MIDI ports have enable bits at 31, 27, 23, 19, 15, 11, 7 and 3, all reset to zero.
// RULE_06 - Each port has a 3-bit plug select just below its enable bit, all reset to zero.
// RULE_07 - A disabled port adds no bytes, an enabled one is carried in the plug slot it selects.
//
// Chosen here: the AXI4-Lite interface to the registers.
`include "itami_consts.svh"

module itami_top (
  // Clock and reset.
  input  logic                       aclk,
  input  logic                       aresetn,
  // Register bus.
  input  itami_pkg::itami_axil_req_t axil_req,
  output itami_pkg::itami_axil_rsp_t axil_rsp,
  // Quadlets from the sample packer.
  input  logic                       s_valid,
  input  itami_pkg::itami_quad_t     s_quad,
  output logic                       s_ready,
  // Quadlets to the packet builder.
  output logic                       m_valid,
  output itami_pkg::itami_quad_t     m_quad,
  input  logic                       m_ready,
  // MIDI port sources.
  input  logic [7:0]                 midi_valid,
  input  logic [7:0][7:0]            midi_byte,
  output logic [7:0]                 midi_ack,
  // Configuration seen by the packet builder.
  output logic                       mute_n,
  output logic                       midi_insert_on
);

  localparam itami_pkg::itami_top_st_t ST_RST = '{
    awready:  1'b1,
    wready:   1'b1,
    arready:  1'b1,
    port_map: `ITAMI_MAP_RESET,
    default:  '0
  };

  itami_pkg::itami_top_st_t st_q;
  itami_pkg::itami_top_st_t st_d;

  itami_pkg::itami_quad_t   quad_in;
  logic                     in_take;
  logic                     pick_hit;
  logic [2:0]               pick_port;
  logic [7:0]               pick_byte;
  logic [7:0]               src_valid;
  logic [31:0]              cfg_word;

  // A port already acknowledged is kept out of the choice for the one cycle its acknowledge is high.
  assign src_valid = midi_valid & ~st_q.midi_ack;

  itami_midi_pick u_pick (
    .port_map  (st_q.port_map),
    .plug      (s_quad.plug),
    .src_valid (src_valid),
    .src_byte  (midi_byte),
    .hit       (pick_hit),
    .port      (pick_port),
    .pick_byte (pick_byte)
  );

  itami_out_stage u_stage (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (s_valid),
    .in_quad   (quad_in),
    .in_ready  (s_ready),
    .mute_n    (st_q.mute_n),
    .out_valid (m_valid),
    .out_quad  (m_quad),
    .out_ready (m_ready)
  );

  assign in_take = s_valid && s_ready;

  always_comb begin
    cfg_word = `ITAMI_CFG_RESET;
    cfg_word[`ITAMI_CFG_MUTE_N_BIT]  = st_q.mute_n;
    cfg_word[`ITAMI_CFG_MIDI_ON_BIT] = st_q.midi_insert_on;
  end

  // Quadlet offered to the output stage.
  always_comb begin
    quad_in = s_quad;
    if (st_q.midi_insert_on && s_quad.last) begin // [RULE_03] [RULE_04]
      if (pick_hit) begin
        quad_in.data = {`ITAMI_MIDI_LABEL_DATA, pick_byte, `ITAMI_MIDI_PAD}; // [RULE_07]
      end else begin
        quad_in.data = {`ITAMI_MIDI_LABEL_EMPTY, `ITAMI_MIDI_NO_BYTE, `ITAMI_MIDI_PAD};
      end
    end
    if (!st_q.mute_n) begin
      quad_in.data = `ITAMI_MUTED_WORD; // [RULE_01]
    end
  end

  always_comb begin
    st_d = st_q;

    // Write address and write data are taken in either order.
    if (axil_req.awvalid && st_q.awready) begin
      st_d.awaddr  = axil_req.awaddr;
      st_d.awready = 1'b0;
    end
    if (axil_req.wvalid && st_q.wready) begin
      st_d.wdata  = axil_req.wdata;
      st_d.wstrb  = axil_req.wstrb;
      st_d.wready = 1'b0;
    end
    if (st_q.bvalid && axil_req.bready) begin
      st_d.bvalid = 1'b0;
    end

    // Counters; a clear by software and an event in the same cycle leave the event counted.
    st_d.midi_ack = 8'h00;

    // Both halves held and no response pending: perform the write.
    if (!st_q.awready && !st_q.wready && !st_q.bvalid) begin
      st_d.bvalid  = 1'b1;
      st_d.bresp   = `ITAMI_RESP_OKAY;
      st_d.awready = 1'b1;
      st_d.wready  = 1'b1;
      case (st_q.awaddr)
        `ITAMI_ADDR_CFG: begin
          if (st_q.wstrb[3]) begin
            st_d.mute_n         = st_q.wdata[`ITAMI_CFG_MUTE_N_BIT]; // [RULE_02]
            st_d.midi_insert_on = st_q.wdata[`ITAMI_CFG_MIDI_ON_BIT];
          end
        end
        `ITAMI_ADDR_MAP: begin
          st_d.port_map = itami_pkg::apply_strb(st_q.port_map, st_q.wdata, st_q.wstrb); // [RULE_05] [RULE_06]
        end
        `ITAMI_ADDR_STAT: begin
          if (st_q.wstrb[1:0] != 2'b00) begin
            st_d.midi_cnt = 16'h0000;
          end
          if (st_q.wstrb[3:2] != 2'b00) begin
            st_d.blk_cnt = 16'h0000;
          end
        end
        default: begin
          st_d.bresp = `ITAMI_RESP_SLVERR;
        end
      endcase
    end

    // Read channel.
    if (st_q.rvalid && axil_req.rready) begin
      st_d.rvalid  = 1'b0;
      st_d.arready = 1'b1;
    end
    if (axil_req.arvalid && st_q.arready) begin
      st_d.arready = 1'b0;
      st_d.rvalid  = 1'b1;
      st_d.rresp   = `ITAMI_RESP_OKAY;
      case (axil_req.araddr)
        `ITAMI_ADDR_CFG: begin
          st_d.rdata = cfg_word;
        end
        `ITAMI_ADDR_MAP: begin
          st_d.rdata = st_q.port_map;
        end
        `ITAMI_ADDR_STAT: begin
          st_d.rdata = {st_q.blk_cnt, st_q.midi_cnt};
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = `ITAMI_RESP_SLVERR;
        end
      endcase
    end

    // MIDI byte consumed only when it really leaves in a data block.
    if (in_take && st_q.midi_insert_on && s_quad.last && st_q.mute_n && pick_hit) begin // [RULE_03]
      st_d.midi_ack[pick_port] = 1'b1; // [RULE_07]
      st_d.midi_cnt            = st_d.midi_cnt + 16'h0001;
    end
    if (in_take && s_quad.last) begin
      st_d.blk_cnt = st_d.blk_cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_RST; // [RULE_02] [RULE_05] [RULE_06]
    end else begin
      st_q <= st_d;
    end
  end

  assign axil_rsp.awready = st_q.awready;
  assign axil_rsp.wready  = st_q.wready;
  assign axil_rsp.bresp   = st_q.bresp;
  assign axil_rsp.bvalid  = st_q.bvalid;
  assign axil_rsp.arready = st_q.arready;
  assign axil_rsp.rdata   = st_q.rdata;
  assign axil_rsp.rresp   = st_q.rresp;
  assign axil_rsp.rvalid  = st_q.rvalid;
  assign midi_ack         = st_q.midi_ack;
  assign mute_n           = st_q.mute_n;
  assign midi_insert_on   = st_q.midi_insert_on;

endmodule

// *** dv/itami_top_properties.sv ***
// Purpose: Port checks of the audio and MIDI insertion block.
// Assumes: Bound to itami_top; one clock.
// Notes:   Stream checks skip a cycle in which a setting has just changed.
`include "itami_consts.svh"

module itami_top_properties (
  // Clock and reset.
  input logic                   aclk,
  input logic                   aresetn,
  // Stream.
  input itami_pkg::itami_quad_t s_quad,
  input logic                   m_valid,
  input itami_pkg::itami_quad_t m_quad,
  // MIDI and settings.
  input logic [7:0]             midi_valid,
  input logic [7:0][7:0]        midi_byte,
  input logic [7:0]             midi_ack,
  input logic                   mute_n,
  input logic                   midi_insert_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] byte_q;
  logic [7:0]  pick;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk) byte_q <= midi_byte;

  always_comb begin
    pick = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (midi_ack[i]) pick = pick | byte_q[8*i +: 8];
    end
  end

  sequence s_new;
    $rose(m_valid) && mute_n && $past(mute_n) && midi_insert_on == $past(midi_insert_on);
  endsequence

  property p_mute_zero;
    m_valid && !mute_n && !$past(mute_n) |-> m_quad.data == `ITAMI_MUTED_WORD;
  endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("muted quadlet not zero");

  property p_midi_slot;
    s_new ##0 midi_insert_on && m_quad.last |-> m_quad.data[31:25] == 7'h40 && m_quad.data[15:0] == 16'h0000;
  endproperty
  a_midi_slot: assert property (p_midi_slot) else $error("last quadlet lacks MIDI form");

  property p_pass;
    s_new ##0 !midi_insert_on |-> m_quad.data == $past(s_quad.data);
  endproperty
  a_pass: assert property (p_pass) else $error("sample altered with MIDI off");

  property p_ack_cfg;
    midi_ack != 8'h00 |-> $past(midi_insert_on) && $past(mute_n);
  endproperty
  a_ack_cfg: assert property (p_ack_cfg) else $error("MIDI byte taken while off");

  property p_ack;
    midi_ack != 8'h00 |-> $onehot(midi_ack) && $rose(m_valid) && ($past(midi_valid) & midi_ack) == midi_ack
      && m_quad.data[31:16] == {`ITAMI_MIDI_LABEL_DATA, pick};
  endproperty
  a_ack: assert property (p_ack) else $error("MIDI byte not carried");

  property p_empty;
    s_new ##0 midi_insert_on && m_quad.last && midi_ack == 8'h00 |-> m_quad.data == 32'h8000_0000;
  endproperty
  a_empty: assert property (p_empty) else $error("empty MIDI slot wrong");

  c_muted: cover property (m_valid && !mute_n);
  c_ack: cover property (midi_ack != 8'h00);
  c_empty: cover property (m_valid && midi_insert_on && m_quad.data[31:24] == `ITAMI_MIDI_LABEL_EMPTY);
endmodule

// *** dv/itami_far_end.sv ***
// Purpose: MIDI sources and packet builder sink facing the insertion block.
// Assumes: Runs on aclk; slow makes the sink stall at random.
// Notes:   An idle source shows a fresh byte every cycle, never a stale one.
module itami_far_end (
  // Clock and reset.
  input  logic            aclk,
  input  logic            aresetn,
  input  logic            slow,
  // MIDI sources.
  input  logic [7:0]      midi_ack,
  output logic [7:0]      midi_valid,
  output logic [7:0][7:0] midi_byte,
  // Packet builder.
  output logic            m_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 32'hb8b2_1432;

  initial begin
    midi_valid = 8'h00;
    midi_byte = '0;
    m_ready = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      midi_valid <= 8'h00;
      m_ready <= 1'b0;
    end else begin
      m_ready <= slow ? 1'($random(seed)) : 1'b1;
      for (int i = 0; i < 8; i++) begin
        // A pending byte stays put until its acknowledge is seen.
        if (midi_ack[i] || !midi_valid[i]) begin
          midi_valid[i] <= 1'($random(seed));
          midi_byte[i] <= 8'($random(seed));
        end
      end
    end
  end
endmodule

// *** dv/tb_itami_top.sv ***
// Purpose: Self-checking bench of the audio and MIDI insertion block.
// Assumes: itami_far_end plays the MIDI sources and the packet builder.
// Notes:   Silence is only changed while the output stage is empty.
`include "itami_consts.svh"

module tb_itami_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       aclk;
  logic                       aresetn;
  itami_pkg::itami_axil_req_t req;
  itami_pkg::itami_axil_rsp_t rsp;
  logic                       s_valid;
  itami_pkg::itami_quad_t     s_quad;
  logic                       s_ready;
  logic                       m_valid;
  itami_pkg::itami_quad_t     m_quad;
  logic                       m_ready;
  logic [7:0]                 midi_valid;
  logic [7:0][7:0]            midi_byte;
  logic [7:0]                 midi_ack;
  logic                       mute_n;
  logic                       midi_insert_on;
  logic                       slow;
  logic [31:0]                cfg_m;
  logic [31:0]                map_m;
  logic [31:0]                stat_m;
  logic [31:0]                exp_q[$];
  integer                     seed = 32'hb8b2_1432;
  int                         fails = 0;
  int                         comparisons = 0;

  itami_top itami_top_i (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp), .s_valid(s_valid),
    .s_quad(s_quad), .s_ready(s_ready), .m_valid(m_valid), .m_quad(m_quad), .m_ready(m_ready),
    .midi_valid(midi_valid), .midi_byte(midi_byte), .midi_ack(midi_ack), .mute_n(mute_n),
    .midi_insert_on(midi_insert_on));
  itami_far_end itami_far_end_i (.aclk(aclk), .aresetn(aresetn), .slow(slow), .midi_ack(midi_ack),
    .midi_valid(midi_valid), .midi_byte(midi_byte), .m_ready(m_ready));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] exp_word(input itami_pkg::itami_quad_t q, input logic [7:0] mv,
                                           input logic [63:0] mb);
    if (!cfg_m[31]) return 32'h0000_0000;
    if (!cfg_m[30] || !q.last) return q.data;
    for (int i = 0; i < 8; i++) begin
      if (map_m[4*i+3] && map_m[4*i +: 3] == q.plug && mv[i]) return {8'h81, mb[8*i +: 8], 16'h0000};
    end
    return 32'h8000_0000;
  endfunction

  function automatic logic [31:0] exp_resp(input logic [31:0] a);
    return (a == `ITAMI_ADDR_CFG || a == `ITAMI_ADDR_MAP || a == `ITAMI_ADDR_STAT) ? 32'h0000_0000 : 32'h0000_0002;
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw;
    logic w;
    logic b;
    logic [1:0] r;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      #1;
      aw = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      b = rsp.bvalid;
      r = rsp.bresp;
      @(posedge aclk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end while (!b);
    req.bready <= 1'b0;
    if (a == `ITAMI_ADDR_CFG && s[3]) cfg_m[31:30] = d[31:30];
    for (int i = 0; i < 4; i++) begin
      if (a == `ITAMI_ADDR_MAP && s[i]) map_m[8*i +: 8] = d[8*i +: 8];
    end
    if (a == `ITAMI_ADDR_STAT && s[1:0] != 2'b00) stat_m[15:0] = 16'h0000;
    if (a == `ITAMI_ADDR_STAT && s[3:2] != 2'b00) stat_m[31:16] = 16'h0000;
    chk(32'(r), exp_resp(a));
  endtask

  task automatic rd(input logic [31:0] a);
    logic ar;
    logic rv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      #1;
      ar = req.arvalid && rsp.arready;
      rv = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge aclk);
      if (ar) req.arvalid <= 1'b0;
    end while (!rv);
    req.rready <= 1'b0;
    chk(d, a == `ITAMI_ADDR_CFG ? cfg_m : a == `ITAMI_ADDR_MAP ? map_m : a == `ITAMI_ADDR_STAT ? stat_m : 32'h0000_0000);
    chk(32'(r), exp_resp(a));
  endtask

  task automatic burst(input int n);
    logic hs;
    logic [31:0] e;
    itami_pkg::itami_quad_t q;
    for (int k = 0; k < n; k++) begin
      q = {1'($random(seed)), 3'($random(seed)), 32'($random(seed))};
      @(posedge aclk);
      s_valid <= 1'b1;
      s_quad <= q;
      do begin
        #1;
        hs = s_ready;
        if (hs) begin
          e = exp_word(q, midi_valid, midi_byte);
          exp_q.push_back(e);
          if (q.last) stat_m[31:16] = stat_m[31:16] + 16'h0001;
          if (q.last && cfg_m[30] && e[31:24] == 8'h81) stat_m[15:0] = stat_m[15:0] + 16'h0001;
        end
        @(posedge aclk);
      end while (!hs);
      s_valid <= 1'b0;
    end
    // The stage fills at the take edge itself, so its valid is looked at only once settled.
    #1;
    while (m_valid) begin
      @(posedge aclk);
      #1;
    end
  endtask

  always @(negedge aclk) begin
    if (aresetn && m_valid && m_ready) chk(m_quad.data, exp_q.pop_front());
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    give_verdict();
  end

  initial begin
    aresetn = 1'b0;
    req = '0;
    s_valid = 1'b0;
    s_quad = '0;
    slow = 1'b0;
    cfg_m = '0;
    map_m = '0;
    stat_m = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'({mute_n, midi_insert_on}), 32'h0000_0000);
    rd(`ITAMI_ADDR_CFG);
    rd(`ITAMI_ADDR_MAP);
    burst(8);
    $display("test reset and silence done");
    wr(32'hcf00_00e0, 32'hffff_ffff, 4'hf);
    rd(32'hcf00_00e0);
    wr(`ITAMI_ADDR_MAP, 32'hffff_ffff, 4'h5);
    rd(`ITAMI_ADDR_MAP);
    wr(`ITAMI_ADDR_CFG, 32'hc000_0000, 4'h7);
    rd(`ITAMI_ADDR_CFG);
    $display("test registers done");
    for (int k = 0; k < 40; k++) begin
      slow = k[0];
      wr(`ITAMI_ADDR_CFG, k < 3 ? 32'hc000_0000 : $random(seed), 4'hf);
      chk(32'({mute_n, midi_insert_on}), 32'(cfg_m[31:30]));
      wr(`ITAMI_ADDR_MAP, k == 0 ? 32'hffff_ffff : k == 1 ? 32'h8888_8888 : k == 2 ? 32'h0 : $random(seed), 4'hf);
      rd(`ITAMI_ADDR_MAP);
      burst(24);
    end
    $display("test random stream done");
    rd(`ITAMI_ADDR_STAT);
    wr(`ITAMI_ADDR_STAT, 32'h0000_0000, 4'h3);
    rd(`ITAMI_ADDR_STAT);
    wr(`ITAMI_ADDR_STAT, 32'h0000_0000, 4'hc);
    rd(`ITAMI_ADDR_STAT);
    $display("test status counters done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cfg_m = '0;
    map_m = '0;
    stat_m = '0;
    rd(`ITAMI_ADDR_CFG);
    rd(`ITAMI_ADDR_MAP);
    rd(`ITAMI_ADDR_STAT);
    chk(32'({mute_n, midi_insert_on}), 32'h0000_0000);
    $display("test second reset done");
    give_verdict();
  end
endmodule

bind itami_top itami_top_properties itami_top_properties_i (.aclk(aclk), .aresetn(aresetn), .s_quad(s_quad),
  .m_valid(m_valid), .m_quad(m_quad), .midi_valid(midi_valid), .midi_byte(midi_byte), .midi_ack(midi_ack),
  .mute_n(mute_n), .midi_insert_on(midi_insert_on));
